// ---- inc/drt_pkg.sv ----
/*
  constants and types for the dual reloading down-timer block.
  assumes an 8-bit register port with byte addresses and one system clock.
*/
package drt_pkg;
  localparam int unsigned CNT_WIDTH = 16;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 8;

  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h02;
  localparam logic [7:0] ADDR_T1_RELOAD_LOW = 8'h03;
  localparam logic [7:0] ADDR_T1_RELOAD_HIGH = 8'h04;
  localparam logic [7:0] ADDR_T2_RELOAD_LOW = 8'h05;
  localparam logic [7:0] ADDR_T2_RELOAD_HIGH = 8'h06;
  localparam logic [7:0] ADDR_OP_CONTROL_A = 8'h09;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0b;

  localparam int unsigned BIT_T1_IRQ = 2;
  localparam int unsigned BIT_T2_IRQ = 1;
  localparam int unsigned BIT_T1_ON = 2;
  localparam int unsigned BIT_T2_ON = 3;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] ALL_ONES = 16'hffff;

  localparam logic [1:0] DIV_PHASES = 2'h3;
  localparam logic [1:0] DIV_LAST_PHASE = 2'h2;

  typedef enum logic [1:0] {
    DRT_MODE_DUAL = 2'b00,
    DRT_MODE_FAST = 2'b01,
    DRT_MODE_SLOW = 2'b10
  } drt_clk_mode_type;
endpackage

// ---- logic/drt_counter.sv ----
/*
  one 16-bit reloading down-counter with a registered underflow pulse.
  assumes tick is a one-cycle strobe on the system clock.
*/
module drt_counter #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] reload_in,
  output logic [WIDTH-1:0] count_out,
  output logic underflow_out
);
  logic [WIDTH-1:0] count_r;
  logic underflow_r;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count_r <= '0;
    end
    else if (enable_in && tick_in)
    begin
      if (count_r == '0)
      begin
        count_r <= reload_in;
      end
      else
      begin
        count_r <= count_r - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      underflow_r <= 1'b0;
    end
    else
    begin
      underflow_r <= enable_in && tick_in && (count_r == '0);
    end
  end

  assign count_out = count_r;
  assign underflow_out = underflow_r;
endmodule

// ---- logic/drt_timers.sv ----
/*
  two reloading down-timers with preload bytes, enables and gated interrupts.
  assumes oscillator pins are asynchronous, the system tick and mode come
  from logic on MCLK_IN, and the core acknowledges interrupts by a pulse.
*/
// What this block does
// - timer one has a 16-bit down-counter and write-only low and high preload bytes
// - timer one decrements by one per selected clock pulse when enabled, else holds
// - timer one taking a pulse while at zero (underflow) raises its interrupt request
// - on that wrap timer one reloads from its preload pair automatically
// - preload N gives one timer one interrupt every N plus one pulses
// - reset clears timer one counter, so first enabled pulse underflows and reloads
// - timer one counts slow oscillator in dual or slow mode, fast in fast mode
// - timer two counts system tick divided by one and a half
// - timer two has its own preload bytes, wraps, interrupts and reloads
// - preload N gives one timer two interrupt every N plus one pulses
// - reset clears timer two counter, first enabled pulse underflows immediately
// - timer one interrupt gated by enable bit 2 at address 0x02, reset off
// - timer two interrupt gated by enable bit 1 at address 0x02, reset off
// - timer one counting enabled by bit 2 at address 0x09, reset off
// - timer two counting enabled by bit 3 at address 0x09, reset off
// - timer one preload low at 0x03, high at 0x04
// - timer two preload low at 0x05, high at 0x06
module drt_timers (
  input wire logic MCLK_IN,
  input wire logic RESET_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic SLOW_OSC_IN,
  input wire logic FAST_OSC_IN,
  input wire logic [1:0] CLOCK_MODE_IN,
  input wire logic SYS_TICK_IN,
  input wire logic IRQ1_ACK_IN,
  input wire logic IRQ2_ACK_IN,
  output logic TIMER1_IRQ_OUT,
  output logic TIMER2_IRQ_OUT,
  output logic IRQ_OUT
);
  localparam int unsigned W = drt_pkg::CNT_WIDTH;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // oscillator pin synchronisers, index 0 slow, 1 fast
  logic [1:0] osc_pin;
  logic [1:0] osc_meta_r;
  logic [1:0] osc_sync_r;
  logic [1:0] osc_prev_r;
  logic [1:0] osc_edge;

  // register state
  logic [7:0] t1_low_r;
  logic [7:0] t1_high_r;
  logic [7:0] t2_low_r;
  logic [7:0] t2_high_r;
  logic timer1_irq_enable_r;
  logic timer2_irq_enable_r;
  logic timer1_count_enable_r;
  logic timer2_count_enable_r;
  logic t1_pending_r;
  logic t2_pending_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // clocking and counters
  logic [1:0] div_phase_r;
  logic t1_tick;
  logic t2_tick;
  logic [1:0] cnt_tick;
  logic [1:0] cnt_en;
  logic [1:0][W-1:0] cnt_reload;
  logic [1:0][W-1:0] cnt_value;
  logic [1:0] cnt_uf;
  logic wr_status;
  drt_pkg::drt_clk_mode_type mode;

  assign osc_pin = {FAST_OSC_IN, SLOW_OSC_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge MCLK_IN)
      begin
        if (RESET_IN)
        begin
          osc_meta_r[gi] <= 1'b0;
          osc_sync_r[gi] <= 1'b0;
          osc_prev_r[gi] <= 1'b0;
        end
        else
        begin
          osc_meta_r[gi] <= osc_pin[gi];
          osc_sync_r[gi] <= osc_meta_r[gi];
          osc_prev_r[gi] <= osc_sync_r[gi];
        end
      end
      assign osc_edge[gi] = osc_sync_r[gi] && !osc_prev_r[gi];
    end
  endgenerate

  assign mode = drt_pkg::drt_clk_mode_type'(CLOCK_MODE_IN);

  // timer one clock source select
  always_comb
  begin
    unique case (mode)
      drt_pkg::DRT_MODE_FAST: t1_tick = osc_edge[1];
      drt_pkg::DRT_MODE_DUAL: t1_tick = osc_edge[0];
      drt_pkg::DRT_MODE_SLOW: t1_tick = osc_edge[0];
      default: t1_tick = osc_edge[0];
    endcase
  end

  // system tick divided by 1.5: two pulses out of every three
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      div_phase_r <= 2'h0;
    end
    else if (SYS_TICK_IN)
    begin
      if (div_phase_r == drt_pkg::DIV_LAST_PHASE)
      begin
        div_phase_r <= 2'h0;
      end
      else
      begin
        div_phase_r <= div_phase_r + 2'h1;
      end
    end
  end

  assign t2_tick = SYS_TICK_IN && (div_phase_r != drt_pkg::DIV_LAST_PHASE);

  assign cnt_tick = {t2_tick, t1_tick};
  assign cnt_en = {timer2_count_enable_r, timer1_count_enable_r};
  assign cnt_reload[0] = {t1_high_r, t1_low_r};
  assign cnt_reload[1] = {t2_high_r, t2_low_r};

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cnt
      // counters reset to zero, wrap and reload
      drt_counter #(
        .WIDTH(W)
      ) u_cnt (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .tick_in(cnt_tick[gi]),
        .enable_in(cnt_en[gi]),
        .reload_in(cnt_reload[gi]),
        .count_out(cnt_value[gi]),
        .underflow_out(cnt_uf[gi])
      );
    end
  endgenerate

  // write-only preload bytes
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      t1_low_r <= drt_pkg::RST_BYTE;
      t1_high_r <= drt_pkg::RST_BYTE;
      t2_low_r <= drt_pkg::RST_BYTE;
      t2_high_r <= drt_pkg::RST_BYTE;
    end
    else if (REG_WR_IN)
    begin
      if (hit(REG_ADDR_IN, drt_pkg::ADDR_T1_RELOAD_LOW))
        t1_low_r <= REG_WDATA_IN;
      if (hit(REG_ADDR_IN, drt_pkg::ADDR_T1_RELOAD_HIGH))
        t1_high_r <= REG_WDATA_IN;
      if (hit(REG_ADDR_IN, drt_pkg::ADDR_T2_RELOAD_LOW))
        t2_low_r <= REG_WDATA_IN;
      if (hit(REG_ADDR_IN, drt_pkg::ADDR_T2_RELOAD_HIGH))
        t2_high_r <= REG_WDATA_IN;
    end
  end

  // interrupt enables and count enables
  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      timer1_irq_enable_r <= 1'b0;
      timer2_irq_enable_r <= 1'b0;
      timer1_count_enable_r <= 1'b0;
      timer2_count_enable_r <= 1'b0;
    end
    else if (REG_WR_IN)
    begin
      if (hit(REG_ADDR_IN, drt_pkg::ADDR_IRQ_ENABLE))
      begin
        timer1_irq_enable_r <= REG_WDATA_IN[drt_pkg::BIT_T1_IRQ];
        timer2_irq_enable_r <= REG_WDATA_IN[drt_pkg::BIT_T2_IRQ];
      end
      if (hit(REG_ADDR_IN, drt_pkg::ADDR_OP_CONTROL_A))
      begin
        timer1_count_enable_r <= REG_WDATA_IN[drt_pkg::BIT_T1_ON];
        timer2_count_enable_r <= REG_WDATA_IN[drt_pkg::BIT_T2_ON];
      end
    end
  end

  // sticky pending flags: set beats ack and write-one clear
  assign wr_status = REG_WR_IN && hit(REG_ADDR_IN, drt_pkg::ADDR_IRQ_STATUS);

  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      t1_pending_r <= 1'b0;
      t2_pending_r <= 1'b0;
    end
    else
    begin
      if (cnt_uf[0])
        t1_pending_r <= 1'b1;
      else if (IRQ1_ACK_IN || (wr_status && REG_WDATA_IN[drt_pkg::BIT_T1_IRQ]))
        t1_pending_r <= 1'b0;
      if (cnt_uf[1])
        t2_pending_r <= 1'b1;
      else if (IRQ2_ACK_IN || (wr_status && REG_WDATA_IN[drt_pkg::BIT_T2_IRQ]))
        t2_pending_r <= 1'b0;
    end
  end

  assign TIMER1_IRQ_OUT = t1_pending_r && timer1_irq_enable_r;
  assign TIMER2_IRQ_OUT = t2_pending_r && timer2_irq_enable_r;
  assign IRQ_OUT = TIMER1_IRQ_OUT || TIMER2_IRQ_OUT;

  // read mux, data stand one cycle after the strobe
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (REG_RD_IN)
    begin
      if (hit(REG_ADDR_IN, drt_pkg::ADDR_IRQ_ENABLE))
      begin
        rdata_nxt[drt_pkg::BIT_T1_IRQ] = timer1_irq_enable_r;
        rdata_nxt[drt_pkg::BIT_T2_IRQ] = timer2_irq_enable_r;
      end
      else if (hit(REG_ADDR_IN, drt_pkg::ADDR_OP_CONTROL_A))
      begin
        rdata_nxt[drt_pkg::BIT_T1_ON] = timer1_count_enable_r;
        rdata_nxt[drt_pkg::BIT_T2_ON] = timer2_count_enable_r;
      end
      else if (hit(REG_ADDR_IN, drt_pkg::ADDR_IRQ_STATUS))
      begin
        rdata_nxt[drt_pkg::BIT_T1_IRQ] = t1_pending_r;
        rdata_nxt[drt_pkg::BIT_T2_IRQ] = t2_pending_r;
      end
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
      rdata_r <= drt_pkg::RST_BYTE;
    else
      rdata_r <= rdata_nxt;
  end

  assign REG_RDATA_OUT = rdata_r;

  // checks
  sequence s_t1_wrap_step;
    cnt_en[0] && cnt_tick[0] && (cnt_value[0] == drt_pkg::RST_COUNT);
  endsequence

  sequence s_t1_reloaded;
    (cnt_value[0] == $past(cnt_reload[0])) ##0 cnt_uf[0] ##1 t1_pending_r;
  endsequence

  a_t1_wrap_reload: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    s_t1_wrap_step |=> s_t1_reloaded)
    else $error("timer one did not reload and flag on wrap");

  a_t1_count_step: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    cnt_en[0] && cnt_tick[0] && (cnt_value[0] != drt_pkg::RST_COUNT)
      |=> cnt_value[0] == $past(cnt_value[0]) - 16'h0001)
    else $error("timer one did not decrement by one");

  a_t1_hold_off: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    !cnt_en[0] |=> $stable(cnt_value[0]))
    else $error("timer one moved while disabled");

  a_t2_wrap_flag: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    cnt_en[1] && cnt_tick[1] && (cnt_value[1] == drt_pkg::RST_COUNT)
      |=> cnt_uf[1] ##1 t2_pending_r)
    else $error("timer two wrap did not raise its request");

  a_t2_reload: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    cnt_en[1] && cnt_tick[1] && (cnt_value[1] == drt_pkg::RST_COUNT)
      |=> cnt_value[1] == $past(cnt_reload[1]))
    else $error("timer two did not reload on wrap");

  a_t2_count_step: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    cnt_en[1] && cnt_tick[1] && (cnt_value[1] != drt_pkg::RST_COUNT)
      |=> cnt_value[1] == $past(cnt_value[1]) - 16'h0001)
    else $error("timer two did not decrement by one");

  a_t2_hold_off: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    !cnt_en[1] |=> $stable(cnt_value[1]))
    else $error("timer two moved while disabled");

  a_t2_div_ratio: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    SYS_TICK_IN && (div_phase_r == drt_pkg::DIV_LAST_PHASE) |-> !t2_tick ##1 (div_phase_r == 2'h0))
    else $error("timer two ticked on the skipped phase");

  a_div_range: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    div_phase_r != drt_pkg::DIV_PHASES)
    else $error("divider phase out of range");

  a_t1_src_fast: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (mode == drt_pkg::DRT_MODE_FAST) |-> (t1_tick == osc_edge[1]))
    else $error("timer one not clocked from fast oscillator");

  a_reset_clear: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    $past(RESET_IN) |-> (cnt_value[0] == drt_pkg::RST_COUNT) && (cnt_value[1] == drt_pkg::RST_COUNT)
      && !timer1_count_enable_r && !timer2_count_enable_r && !IRQ_OUT)
    else $error("state not cleared by reset");

  a_pending_hold: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    t1_pending_r && !IRQ1_ACK_IN && !wr_status |=> t1_pending_r)
    else $error("timer one request dropped before acceptance");

  a_irq_gate: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    !timer2_irq_enable_r |-> !TIMER2_IRQ_OUT)
    else $error("masked timer two request forwarded");

  a_t1_irq_gate: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    !timer1_irq_enable_r |-> !TIMER1_IRQ_OUT)
    else $error("masked timer one request forwarded");

  a_status_read: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    REG_RD_IN && hit(REG_ADDR_IN, drt_pkg::ADDR_IRQ_STATUS)
      |=> REG_RDATA_OUT[drt_pkg::BIT_T1_IRQ] == $past(t1_pending_r))
    else $error("timer one pending bit misread");

  a_wo_readback: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    REG_RD_IN && hit(REG_ADDR_IN, drt_pkg::ADDR_T1_RELOAD_LOW) |=> REG_RDATA_OUT == 8'h00)
    else $error("preload byte read back");

  a_enable_write: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    REG_WR_IN && hit(REG_ADDR_IN, drt_pkg::ADDR_IRQ_ENABLE)
      |=> timer1_irq_enable_r == $past(REG_WDATA_IN[drt_pkg::BIT_T1_IRQ]))
    else $error("timer one interrupt enable not written");
endmodule

// ---- test/tb.sv ----
/*
  self-checking bench for the dual reloading down-timers.
  assumes one 100 MHz clock and the design's own assertions inside it.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic sosc = 1'b0;
  logic fosc = 1'b0;
  logic [1:0] mode = 2'h0;
  logic tick = 1'b0;
  logic ack1 = 1'b0;
  logic ack2 = 1'b0;
  logic [7:0] rdata;
  logic irq1;
  logic irq2;
  logic irq;
  int errors = 0;
  int n_checks = 0;

  drt_timers dut (
    .MCLK_IN(clk), .RESET_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .SLOW_OSC_IN(sosc),
    .FAST_OSC_IN(fosc), .CLOCK_MODE_IN(mode), .SYS_TICK_IN(tick), .IRQ1_ACK_IN(ack1),
    .IRQ2_ACK_IN(ack2), .TIMER1_IRQ_OUT(irq1), .TIMER2_IRQ_OUT(irq2), .IRQ_OUT(irq)
  );

  task give_verdict();
    if (errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk_byte(input logic [7:0] exp, input logic [7:0] act);
    n_checks++;
    if (act !== exp)
    begin
      errors++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, act);
    end
  endtask

  task chk_bit(input logic exp, input logic act);
    chk_byte({7'h00, exp}, {7'h00, act});
  endtask

  // let the request path settle, then compare all three lines
  task chk_irq(input logic e1, input logic e2);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(e1, irq1);
    chk_bit(e2, irq2);
    chk_bit(e1 | e2, irq);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk_byte(exp, rdata);
  endtask

  // whole oscillator periods on one pin
  task edges(input logic fast, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (fast)
        fosc <= 1'b1;
      else
        sosc <= 1'b1;
      repeat (5) @(posedge clk);
      fosc <= 1'b0;
      sosc <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask

  task ticks(input int n);
    repeat (n)
    begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask

  task ack(input logic second);
    @(posedge clk);
    if (second)
      ack2 <= 1'b1;
    else
      ack1 <= 1'b1;
    @(posedge clk);
    ack1 <= 1'b0;
    ack2 <= 1'b0;
  endtask

  initial
  begin
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h02, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0b, 8'h00);
    rd(8'h0f, 8'h00);
    wr(8'h03, 8'h5a);
    rd(8'h03, 8'h00);
    wr(8'h02, 8'h06);
    rd(8'h02, 8'h06);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'h0c);
    wr(8'h09, 8'h00);
    chk_irq(1'b0, 1'b0);
    // timer one, preload 1, dual mode
    wr(8'h03, 8'h01);
    wr(8'h04, 8'h00);
    wr(8'h09, 8'h04);
    edges(1'b1, 1);
    chk_irq(1'b0, 1'b0);
    edges(1'b0, 1);
    chk_irq(1'b1, 1'b0);
    rd(8'h0b, 8'h04);
    ack(1'b0);
    chk_irq(1'b0, 1'b0);
    @(posedge clk);
    mode <= drt_pkg::DRT_MODE_FAST;
    edges(1'b0, 2);
    chk_irq(1'b0, 1'b0);
    edges(1'b1, 1);
    chk_irq(1'b0, 1'b0);
    edges(1'b1, 1);
    chk_irq(1'b1, 1'b0);
    wr(8'h0b, 8'h04);
    chk_irq(1'b0, 1'b0);
    @(posedge clk);
    mode <= drt_pkg::DRT_MODE_SLOW;
    edges(1'b1, 2);
    chk_irq(1'b0, 1'b0);
    edges(1'b0, 2);
    chk_irq(1'b1, 1'b0);
    wr(8'h02, 8'h02);
    chk_irq(1'b0, 1'b0);
    rd(8'h0b, 8'h04);
    wr(8'h02, 8'h06);
    chk_irq(1'b1, 1'b0);
    ack(1'b0);
    wr(8'h09, 8'h00);
    edges(1'b0, 3);
    chk_irq(1'b0, 1'b0);
    wr(8'h03, 8'h01);
    wr(8'h04, 8'h01);
    mode <= 2'h3;
    wr(8'h09, 8'h04);
    edges(1'b0, 1);
    chk_irq(1'b0, 1'b0);
    edges(1'b0, 1);
    chk_irq(1'b1, 1'b0);
    ack(1'b0);
    edges(1'b0, 257);
    chk_irq(1'b0, 1'b0);
    edges(1'b0, 1);
    chk_irq(1'b1, 1'b0);
    ack(1'b0);
    // timer two, preload 2
    wr(8'h09, 8'h00);
    wr(8'h05, 8'h02);
    wr(8'h06, 8'h00);
    wr(8'h02, 8'h02);
    wr(8'h09, 8'h08);
    ticks(1);
    chk_irq(1'b0, 1'b1);
    rd(8'h0b, 8'h02);
    ack(1'b1);
    chk_irq(1'b0, 1'b0);
    ticks(3);
    chk_irq(1'b0, 1'b0);
    ticks(1);
    chk_irq(1'b0, 1'b1);
    wr(8'h0b, 8'h02);
    chk_irq(1'b0, 1'b0);
    give_verdict();
  end
endmodule
